// *** design/adc_seq_cfg.svh ***
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// wishbone byte offsets of the two words
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
// control word field positions
`define PM_HI 11
`define PM_LO 10
`define CODING_BIT 9
`define REF_BIT 8
`define CHAN_MSB 7
`define CHAN_LSB 5
`define TYPE_HI 4
`define TYPE_LO 3
`define LIST_SEL_BIT 2
`define CHAIN_EN_BIT 1
`define RANGE_BIT 0
// status word field positions
`define STAT_CHAN_LSB 0
`define STAT_STATE_LSB 3
`define STAT_ARMED_BIT 6
`define STAT_READY_BIT 7
`define STAT_PEND_BIT 8
`define STAT_BUSY_BIT 9
`define STAT_POWER_BIT 10
`define STAT_LIST_LSB 16
// reset values
`define CTRL_RESET 12'h000
`define LIST_RESET 8'h00
// wake-up timing
`define CLK_PERIOD_NS 8
`define WAKE_INT_NS 7000
`define WAKE_EXT_NS 600
`define WAKE_INT_CYCLES ((`WAKE_INT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_EXT_CYCLES ((`WAKE_EXT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** design/adc_seq_pkg.sv ***
package adc_seq_pkg;
   // power management field codes
   typedef enum logic [1:0] {
      POWER_NORMAL = 2'b00,
      POWER_AUTO_SHUTDOWN = 2'b01,
      POWER_AUTO_STANDBY = 2'b10,
      POWER_FULL_SHUTDOWN = 2'b11
   } power_mode_type;
   // input type field codes, {input_type_hi, input_type_lo}
   typedef enum logic [1:0] {
      TYPE_SINGLE = 2'b00,
      TYPE_PSEUDO_PAIR = 2'b01,
      TYPE_DIFF = 2'b10,
      TYPE_PSEUDO_COMMON = 2'b11
   } input_type_type;
   // sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_LIST = 3'b010,
      SEQ_CONSEC = 3'b100
   } seq_state_type;
   // power sequencer states
   typedef enum logic [2:0] {
      PWR_ON = 3'b001,
      PWR_WAKE = 3'b010,
      PWR_DOWN = 3'b100
   } power_state_type;
endpackage

// *** design/adc_sequencer.sv ***
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
// How it works
// - normal mode keeps everything powered always
// - auto shutdown powers off after each conversion
// - standby keeps reference; wake 7us or 600ns
// - full shutdown powers off, control word kept
// - differential: even n against n+1, odd swapped
// - first pseudo type pairs like differential
// - common pseudo: channel against input 7; sequences skip 7
// - sequencer off uses last channel field
// - after 0,1 next write loads list
// - list channels advance on each accepted start edge not in a control write cycle
// - bits 1,0 update fields, sequence continues
// - 1,1 runs channel 0 to final, repeats
// - 12-bit control word, reset to zero
// - ascending from lowest until non-1,0 write
// - pair types skip inverse orientation in sequences; sequencer off converts an odd channel field as given
module adc_sequencer (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // converter pins and core
   input wire logic sample_start_n_i,
   input wire logic conv_done_i,
   output logic conv_start_o,
   output logic [11:0] ctrl_word_o,
   // multiplexer selection
   output logic [2:0] pos_sel_o,
   output logic [2:0] neg_sel_o,
   output logic neg_ground_o,
   // power
   output logic core_power_o,
   output logic ref_power_o
);
   logic sync_meta; // first synchroniser stage
   logic sync_stable; // second synchroniser stage
   logic sync_prev; // delayed copy for edge detect
   logic start_edge; // falling edge seen
   logic [11:0] ctrl_word; // control word
   logic [11:0] next_ctrl; // byte-lane merged write
   logic [7:0] chan_list; // channel list
   logic list_armed; // next write goes to list
   adc_seq_pkg::seq_state_type seq_state; // sequencer state
   logic [2:0] seq_ptr; // sequence position
   logic pending; // start waiting for power
   logic busy; // conversion running
   logic ready; // power up complete
   logic wb_req; // new bus request
   logic wr_ctrl; // write to control offset
   logic take; // start accepted
   logic pair_type; // pairwise input types
   logic [1:0] itype; // input type field
   logic [1:0] pmode; // power field
   logic [2:0] chan_field; // channel field
   logic [7:0] list_ok; // eligible list channels
   logic [7:0] consec_ok; // eligible consecutive channels
   logic [7:0] active_mask; // mask of active sequence
   logic [2:0] used_chan; // channel for this start
   logic [2:0] route_pos; // decoded positive
   logic [2:0] route_neg; // decoded negative
   logic route_gnd; // decoded ground negative
   logic [31:0] status; // status word

   // lowest set bit of a mask
   function automatic logic [2:0] first_set(input logic [7:0] mask);
      logic [2:0] idx;
      idx = 3'h0;
      for (int k = 7; k >= 0; k--) begin
         if (mask[k]) begin
            idx = 3'(k);
         end
      end
      return idx;
   endfunction

   // next set bit above cur, wrapping round
   function automatic logic [2:0] next_set(input logic [2:0] cur, input logic [7:0] mask);
      logic [2:0] idx;
      logic [2:0] probe;
      idx = cur;
      for (int k = 7; k >= 1; k--) begin
         probe = cur + 3'(k);
         if (mask[probe]) begin
            idx = probe;
         end
      end
      return idx;
   endfunction

   assign pmode = ctrl_word[`PM_HI:`PM_LO];
   assign itype = ctrl_word[`TYPE_HI:`TYPE_LO];
   assign chan_field = ctrl_word[`CHAN_MSB:`CHAN_LSB];
   assign pair_type = (itype == adc_seq_pkg::TYPE_DIFF) ||
                      (itype == adc_seq_pkg::TYPE_PSEUDO_PAIR);

   // start pin synchroniser and edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_meta <= 1'b1;
         sync_stable <= 1'b1;
         sync_prev <= 1'b1;
      end else begin
         sync_meta <= sample_start_n_i;
         sync_stable <= sync_meta;
         sync_prev <= sync_stable;
      end
   end
   assign start_edge = sync_prev & ~sync_stable;

   // bus decode
   assign wb_req = cyc_i & stb_i & ~ack_o;
   assign wr_ctrl = wb_req & we_i & (adr_i == `CTRL_OFFSET);
   assign next_ctrl = {sel_i[1] ? dat_i[11:8] : ctrl_word[11:8],
                       sel_i[0] ? dat_i[7:0] : ctrl_word[7:0]};

   // per-channel eligibility
   for (genvar i = 0; i < 8; i++) begin : g_elig
      if (i % 2 == 0) begin : g_even
         assign list_ok[i] = pair_type ? (chan_list[i] & chan_list[i+1]) : chan_list[i];
         assign consec_ok[i] = (3'(i) <= chan_field);
      end else begin : g_odd
         assign list_ok[i] = !pair_type && chan_list[i] &&
                             !(i == 7 && itype == adc_seq_pkg::TYPE_PSEUDO_COMMON);
         assign consec_ok[i] = !pair_type && (3'(i) <= chan_field) &&
                               !(i == 7 && itype == adc_seq_pkg::TYPE_PSEUDO_COMMON);
      end
   end

   // channel for the coming conversion
   always_comb begin
      active_mask = (seq_state == adc_seq_pkg::SEQ_LIST) ? list_ok : consec_ok;
      if (seq_state == adc_seq_pkg::SEQ_IDLE || active_mask == 8'h00) begin
         used_chan = chan_field;
      end else if (active_mask[seq_ptr]) begin
         used_chan = seq_ptr;
      end else begin
         used_chan = first_set(active_mask);
      end
   end

   assign take = start_edge & (pmode != adc_seq_pkg::POWER_FULL_SHUTDOWN) & ~pending & ~busy;

   // control word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_word <= `CTRL_RESET;
      end else if (wr_ctrl && !list_armed) begin
         ctrl_word <= next_ctrl;
      end
   end

   // channel list and sequencer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_list <= `LIST_RESET;
         list_armed <= 1'b0;
         seq_state <= adc_seq_pkg::SEQ_IDLE;
         seq_ptr <= 3'h0;
      end else if (wr_ctrl && list_armed) begin
         if (sel_i[0]) begin
            chan_list <= dat_i[7:0];
         end
         list_armed <= 1'b0;
         seq_state <= adc_seq_pkg::SEQ_LIST;
         seq_ptr <= 3'h0;
      end else if (wr_ctrl) begin
         case ({next_ctrl[`CHAIN_EN_BIT], next_ctrl[`LIST_SEL_BIT]})
            // sequencer off
            2'b00: begin
               seq_state <= adc_seq_pkg::SEQ_IDLE;
            end
            2'b01: begin
               list_armed <= 1'b1;
               seq_state <= adc_seq_pkg::SEQ_IDLE;
            end
            2'b10: begin
               seq_state <= seq_state;
            end
            default: begin
               seq_state <= adc_seq_pkg::SEQ_CONSEC;
               seq_ptr <= 3'h0;
            end
         endcase
      end else if (take && seq_state != adc_seq_pkg::SEQ_IDLE) begin
         seq_ptr <= next_set(used_chan, active_mask);
      end
   end

   // channel decode
   input_route u_route (
      .input_type_i(itype),
      .chan_i(used_chan),
      .pos_o(route_pos),
      .neg_o(route_neg),
      .neg_ground_o(route_gnd)
   );

   // latch selection at the sampling edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_sel_o <= 3'h0;
         neg_sel_o <= 3'h0;
         neg_ground_o <= 1'b1;
      end else if (take) begin
         pos_sel_o <= route_pos;
         neg_sel_o <= route_neg;
         neg_ground_o <= route_gnd;
      end
   end

   // conversion handshake with the core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending <= 1'b0;
         busy <= 1'b0;
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= pending & ready;
         if (take) begin
            pending <= 1'b1;
         end else if (pending && ready) begin
            pending <= 1'b0;
            busy <= 1'b1;
         end else if (busy && conv_done_i) begin
            busy <= 1'b0;
         end
      end
   end

   // power sequencing
   power_control u_power (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .mode_i(pmode),
      .ext_ref_i(~ctrl_word[`REF_BIT]),
      .need_i(pending | busy),
      .core_power_o(core_power_o),
      .ref_power_o(ref_power_o),
      .ready_o(ready)
   );

   // status word
   always_comb begin
      status = 32'h0000_0000;
      status[`STAT_CHAN_LSB +: 3] = used_chan;
      status[`STAT_STATE_LSB +: 3] = seq_state;
      status[`STAT_ARMED_BIT] = list_armed;
      status[`STAT_READY_BIT] = ready;
      status[`STAT_PEND_BIT] = pending;
      status[`STAT_BUSY_BIT] = busy;
      status[`STAT_POWER_BIT] = core_power_o;
      status[`STAT_LIST_LSB +: 8] = chan_list;
   end

   // wishbone answer, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_req;
         if (wb_req && !we_i && adr_i == `STATUS_OFFSET) begin
            dat_o <= status;
         end else begin
            dat_o <= 32'h0000_0000;
         end
      end
   end

   assign ctrl_word_o = ctrl_word;

   // checks
   property p_normal_on;
      @(posedge clk_i) disable iff (rst_i)
      ($past(pmode) == adc_seq_pkg::POWER_NORMAL && $past(core_power_o) &&
       pmode == adc_seq_pkg::POWER_NORMAL) |-> core_power_o;
   endproperty
   a_normal_on: assert property (p_normal_on) else $error("power lost in normal mode");
   property p_auto_off;
      @(posedge clk_i) disable iff (rst_i)
      (pmode == adc_seq_pkg::POWER_AUTO_SHUTDOWN && busy && conv_done_i && !start_edge) ##1
      (pmode == adc_seq_pkg::POWER_AUTO_SHUTDOWN && !start_edge) [*2] |-> !core_power_o;
   endproperty
   a_auto_off: assert property (p_auto_off) else $error("no shutdown after conversion");
   property p_single_route;
      @(posedge clk_i) disable iff (rst_i)
      take && itype == adc_seq_pkg::TYPE_SINGLE |=>
      neg_ground_o && pos_sel_o == $past(used_chan);
   endproperty
   a_single_route: assert property (p_single_route) else $error("bad single route");
   property p_pair_route;
      @(posedge clk_i) disable iff (rst_i)
      take && pair_type |=> !neg_ground_o && neg_sel_o == (pos_sel_o ^ 3'h1);
   endproperty
   a_pair_route: assert property (p_pair_route) else $error("bad pair route");
   property p_common_route;
      @(posedge clk_i) disable iff (rst_i)
      take && itype == adc_seq_pkg::TYPE_PSEUDO_COMMON |=> neg_sel_o == 3'h7;
   endproperty
   a_common_route: assert property (p_common_route) else $error("bad common route");
   property p_idle_chan;
      @(posedge clk_i) disable iff (rst_i)
      take && seq_state == adc_seq_pkg::SEQ_IDLE |=> pos_sel_o == $past(chan_field);
   endproperty
   a_idle_chan: assert property (p_idle_chan) else $error("wrong channel, sequencer off");
   property p_list_load;
      @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && list_armed && sel_i[0] |=>
      chan_list == $past(dat_i[7:0]) && ctrl_word == $past(ctrl_word);
   endproperty
   a_list_load: assert property (p_list_load) else $error("list write misrouted");
   property p_ascend;
      @(posedge clk_i) disable iff (rst_i)
      take && !wr_ctrl && seq_state == adc_seq_pkg::SEQ_LIST && active_mask != 8'h00 |=>
      seq_ptr > $past(used_chan) || seq_ptr == first_set($past(active_mask));
   endproperty
   a_ascend: assert property (p_ascend) else $error("list not ascending");
   property p_keep_seq;
      @(posedge clk_i) disable iff (rst_i)
      wr_ctrl && !list_armed && next_ctrl[`CHAIN_EN_BIT] && !next_ctrl[`LIST_SEL_BIT] |=>
      seq_state == $past(seq_state);
   endproperty
   a_keep_seq: assert property (p_keep_seq) else $error("sequence disturbed");
   property p_consec_range;
      @(posedge clk_i) disable iff (rst_i)
      take && seq_state == adc_seq_pkg::SEQ_CONSEC |-> used_chan <= chan_field;
   endproperty
   a_consec_range: assert property (p_consec_range) else $error("past final channel");
   property p_reset_zero;
      @(posedge clk_i) rst_i |=> ctrl_word == `CTRL_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("control not cleared");
   property p_no_inverse;
      @(posedge clk_i) disable iff (rst_i)
      take && pair_type && seq_state != adc_seq_pkg::SEQ_IDLE && active_mask != 8'h00 |->
      !used_chan[0];
   endproperty
   a_no_inverse: assert property (p_no_inverse) else $error("inverse pair converted");
   c_list_run: cover property (@(posedge clk_i) disable iff (rst_i)
      take && seq_state == adc_seq_pkg::SEQ_LIST);
   c_consec_run: cover property (@(posedge clk_i) disable iff (rst_i)
      take && seq_state == adc_seq_pkg::SEQ_CONSEC);
   c_conv: cover property (@(posedge clk_i) disable iff (rst_i) conv_start_o);
endmodule // adc_sequencer

// *** design/input_route.sv ***
`timescale 1ns/1ps
// channel code to positive / negative multiplexer selection
module input_route (
   // selection request
   input wire logic [1:0] input_type_i,
   input wire logic [2:0] chan_i,
   // multiplexer selection
   output logic [2:0] pos_o,
   output logic [2:0] neg_o,
   output logic neg_ground_o
);
   // pure decode, no state
   always_comb begin
      pos_o = chan_i;
      neg_o = 3'h0;
      neg_ground_o = 1'b0;
      case (input_type_i)
         adc_seq_pkg::TYPE_SINGLE: begin
            neg_ground_o = 1'b1;
         end
         adc_seq_pkg::TYPE_DIFF: begin
            neg_o = chan_i ^ 3'h1;
         end
         adc_seq_pkg::TYPE_PSEUDO_PAIR: begin
            neg_o = chan_i ^ 3'h1;
         end
         adc_seq_pkg::TYPE_PSEUDO_COMMON: begin
            neg_o = 3'h7;
         end
         default: begin
            neg_ground_o = 1'b1;
         end
      endcase
   end
endmodule // input_route

// *** design/power_control.sv ***
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
// power sequencing of core and reference
module power_control (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic [1:0] mode_i,
   input wire logic ext_ref_i,
   input wire logic need_i,
   // power state
   output logic core_power_o,
   output logic ref_power_o,
   output logic ready_o
);
   adc_seq_pkg::power_state_type state; // current state
   adc_seq_pkg::power_state_type next_state; // next state
   logic [9:0] wake_count; // cycles left in wake
   logic [9:0] wake_load; // wake length minus one
   logic auto_mode; // auto shutdown or standby
   assign auto_mode = (mode_i == adc_seq_pkg::POWER_AUTO_SHUTDOWN) ||
                      (mode_i == adc_seq_pkg::POWER_AUTO_STANDBY);
   assign wake_load = ext_ref_i ? 10'(`WAKE_EXT_CYCLES - 1) : 10'(`WAKE_INT_CYCLES - 1);
   // next state decode
   always_comb begin
      next_state = state;
      case (state)
         adc_seq_pkg::PWR_ON: begin
            if (mode_i == adc_seq_pkg::POWER_FULL_SHUTDOWN || (auto_mode && !need_i)) begin
               next_state = adc_seq_pkg::PWR_DOWN;
            end
         end
         adc_seq_pkg::PWR_WAKE: begin
            if (mode_i == adc_seq_pkg::POWER_FULL_SHUTDOWN) begin
               next_state = adc_seq_pkg::PWR_DOWN;
            end else if (wake_count == 10'h000) begin
               next_state = adc_seq_pkg::PWR_ON;
            end
         end
         adc_seq_pkg::PWR_DOWN: begin
            if (mode_i == adc_seq_pkg::POWER_NORMAL || (auto_mode && need_i)) begin
               next_state = adc_seq_pkg::PWR_WAKE;
            end
         end
         default: begin
            next_state = adc_seq_pkg::PWR_DOWN;
         end
      endcase
   end
   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= adc_seq_pkg::PWR_ON;
      end else begin
         state <= next_state;
      end
   end
   // wake counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_count <= 10'h000;
      end else if (state != adc_seq_pkg::PWR_WAKE) begin
         wake_count <= wake_load;
      end else if (wake_count != 10'h000) begin
         wake_count <= wake_count - 10'h001;
      end
   end
   // registered power outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_power_o <= 1'b1;
         ref_power_o <= 1'b1;
         ready_o <= 1'b1;
      end else begin
         core_power_o <= (next_state != adc_seq_pkg::PWR_DOWN);
         ref_power_o <= (next_state != adc_seq_pkg::PWR_DOWN) ||
                        (mode_i == adc_seq_pkg::POWER_AUTO_STANDBY);
         ready_o <= (next_state == adc_seq_pkg::PWR_ON);
      end
   end
   // checks
   property p_standby_ref;
      @(posedge clk_i) disable iff (rst_i)
      ($past(mode_i) == adc_seq_pkg::POWER_AUTO_STANDBY &&
       mode_i == adc_seq_pkg::POWER_AUTO_STANDBY) |-> ref_power_o;
   endproperty
   a_standby_ref: assert property (p_standby_ref) else $error("reference off in standby");
   property p_full_off;
      @(posedge clk_i) disable iff (rst_i)
      ($past(mode_i) == adc_seq_pkg::POWER_FULL_SHUTDOWN &&
       mode_i == adc_seq_pkg::POWER_FULL_SHUTDOWN) |-> !core_power_o && !ref_power_o;
   endproperty
   a_full_off: assert property (p_full_off) else $error("power on in full shutdown");
   property p_ext_wake;
      @(posedge clk_i) disable iff (rst_i)
      (state == adc_seq_pkg::PWR_DOWN && next_state == adc_seq_pkg::PWR_WAKE && ext_ref_i &&
       mode_i == adc_seq_pkg::POWER_AUTO_STANDBY) ##1
      (mode_i == adc_seq_pkg::POWER_AUTO_STANDBY && ext_ref_i) [*8] |-> !ready_o;
   endproperty
   a_ext_wake: assert property (p_ext_wake) else $error("ready too early after wake");
   c_wake: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ready_o));
endmodule // power_control

// *** sim/core_model.sv ***
`timescale 1ns/1ps
// analog core stand-in: one done pulse per start, after a set delay
module core_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // conversion handshake
   input wire logic start_i,
   input wire logic [3:0] delay_i,
   output logic done_o
);
   logic [4:0] cnt; // cycles left in conversion
   // conversion timer
   always_ff @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         cnt <= 5'h00;
      end else if (start_i) begin
         cnt <= {1'b0, delay_i} + 5'h01;
      end else if (cnt == 5'h01) begin
         done_o <= 1'b1;
         cnt <= 5'h00;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
      end
   end
endmodule // core_model

// *** sim/test_adc_sequencer.sv ***
`timescale 1ns/1ps
// self-checking bench for sequencer, routing and power
module test_adc_sequencer;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, start_n = 1'b1;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hf, dly = 4'h1;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic ack_o, conv_start_o, conv_done_i, neg_ground_o, core_power_o, ref_power_o;
   logic [11:0] ctrl_word_o, w;
   logic [2:0] pos_sel_o, neg_sel_o;
   logic [7:0] exp_q[$], e; // expected {care_neg, pos, neg, ground}
   int num_errors = 0, cmp_count = 0, cycles = 0, starts = 0, n;
   always #4 clk_i = ~clk_i;
   adc_sequencer i_adc_sequencer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .sample_start_n_i(start_n), .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
      .ctrl_word_o(ctrl_word_o), .pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o),
      .neg_ground_o(neg_ground_o), .core_power_o(core_power_o), .ref_power_o(ref_power_o));
   core_model i_core_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(conv_start_o),
      .delay_i(dly), .done_o(conv_done_i));
   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one classic bus cycle, held until ack
   task automatic wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= wr;
      sel_i <= 4'hf;
      adr_i <= a;
      dat_i <= d;
      @(posedge clk_i iff ack_o === 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // control write; coding and range bits random, external reference
   task automatic ctl(input logic [1:0] pm, input logic [2:0] ch, input logic [1:0] ty,
                      input logic [1:0] sq);
      n = $urandom;
      w = {pm, n[0], 1'b0, ch, ty, sq[0], sq[1], n[1]};
      wb(1'b1, 4'h0, {20'h0, w});
   endtask
   // start pin pulse with random core delay
   task automatic pulse;
      @(posedge clk_i);
      dly <= 4'($urandom);
      start_n <= 1'b0;
      repeat (2) @(posedge clk_i);
      start_n <= 1'b1;
   endtask
   // note the expected selection, then run one conversion
   task automatic conv(input logic [1:0] ty, input logic [2:0] ch);
      exp_q.push_back(ty == 2'b00 ? {1'b0, ch, 3'h0, 1'b1} :
                      {1'b1, ch, (ty == 2'b11) ? 3'h7 : (ch ^ 3'h1), 1'b0});
      pulse();
      @(posedge clk_i iff conv_done_i === 1'b1);
      repeat (5) @(posedge clk_i);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // watcher: each core start takes the oldest note
   always @(posedge clk_i) begin
      if (conv_start_o === 1'b1) begin
         starts++;
         if (exp_q.size() == 0) begin
            check(32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            check({pos_sel_o, e[7] ? neg_sel_o : 3'h0, neg_ground_o}, {e[6:1], e[0]});
         end
      end
   end
   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         conclude();
      end
   end
   // main sequence
   initial begin
      n = $urandom(79);
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      check({ctrl_word_o, core_power_o, ref_power_o}, {12'h000, 2'b11});
      wb(1'b0, 4'h0, 32'h0);
      check(rd, 32'h0);
      wb(1'b0, 4'h8, 32'h0);
      check(rd, 32'h0);
      $display("test reset done");
      // every type and channel, sequencer off; common type never gets 7
      for (int t = 0; t < 4; t++) for (int c = 0; c < 8; c++) if (!(t == 3 && c == 7)) begin
         ctl(2'b00, 3'(c), 2'(t), 2'b00);
         conv(2'(t), 3'(c));
      end
      $display("test routing done");
      // list of 1,2,5,7 then wrap; a keep write must not restart
      ctl(2'b00, 3'h0, 2'b00, 2'b01);
      wb(1'b1, 4'h0, 32'ha6);
      check(ctrl_word_o, w);
      // status: list a6, list state, channel 1 first, powered and ready
      wb(1'b0, 4'h4, 32'h0);
      check(rd, 32'h00a6_0491);
      for (int c = 0; c < 10; c++) if (8'ha6 >> (c % 8) & 1) conv(2'b00, 3'(c % 8));
      ctl(2'b00, 3'h6, 2'b00, 2'b10);
      conv(2'b00, 3'h2);
      // differential pairs 0/1 and 4/5, one orientation each, then wrap to 0/1
      ctl(2'b00, 3'h0, 2'b10, 2'b01);
      wb(1'b1, 4'h0, 32'h33);
      conv(2'b10, 3'h0);
      conv(2'b10, 3'h4);
      conv(2'b10, 3'h0);
      // consecutive 0..3 then repeat
      ctl(2'b00, 3'h3, 2'b00, 2'b11);
      for (int c = 0; c < 5; c++) conv(2'b00, 3'(c % 4));
      $display("test sequencer done");
      // full shutdown keeps the word and drops starts
      ctl(2'b11, 3'h1, 2'b00, 2'b00);
      repeat (4) @(posedge clk_i);
      check({ctrl_word_o, core_power_o}, {w, 1'b0});
      n = starts;
      pulse();
      repeat (20) @(posedge clk_i);
      check(32'(starts), 32'(n));
      ctl(2'b01, 3'h3, 2'b00, 2'b00);
      conv(2'b00, 3'h3);
      check({core_power_o, ref_power_o}, 2'b00);
      ctl(2'b10, 3'h4, 2'b00, 2'b00);
      conv(2'b00, 3'h4);
      check({core_power_o, ref_power_o}, 2'b01);
      // standby on the internal reference: the long wake must pass first
      wb(1'b1, 4'h0, 32'h980);
      n = cycles;
      conv(2'b00, 3'h4);
      check(32'(cycles - n > 875 && cycles - n < 920), 32'h1);
      ctl(2'b00, 3'h5, 2'b00, 2'b00);
      conv(2'b00, 3'h5);
      check({core_power_o, ref_power_o}, 2'b11);
      check(32'(exp_q.size()), 32'h0);
      $display("test power done");
      conclude();
   end
endmodule // test_adc_sequencer
